// >>> logic/bac_pkg.sv
// package: opcodes, widths, reset values and flag carrier for the binary unit
package bac_pkg;
    localparam int WIDTH = 16;
    localparam int SIGN_BIT = 15;
    localparam int DIGITS = 4;
    localparam logic [15:0] ACC_RESET = 16'h0000;
    localparam logic [15:0] SIGNED_MAX = 16'h7FFF;
    localparam logic [15:0] SIGNED_MIN = 16'h8000;

    typedef enum logic [3:0] {
        BAC_NOP,
        BAC_ADD_TO_ACC_A,
        BAC_ADD_TO_ACC_B,
        BAC_ONES_COMPLEMENT_ACC_A,
        BAC_ONES_COMPLEMENT_ACC_B,
        BAC_TWOS_COMPLEMENT_ACC_A,
        BAC_TWOS_COMPLEMENT_ACC_B,
        BAC_BCD_ADD_ACC_A,
        BAC_CLEAR_EXTEND,
        BAC_CLEAR_OVERFLOW,
        BAC_CLEAR_DECIMAL_CARRY
    } bac_op_t;

    typedef struct packed {
        logic extend;
        logic overflow;
        logic decimal_carry;
    } bac_flags_t;

    typedef struct packed {
        logic [15:0] acc_a;
        logic [15:0] acc_b;
        bac_flags_t flags;
        logic done;
    } bac_state_t;
endpackage : bac_pkg

// >>> logic/bac_unit.sv
// binary add, one's and two's complement unit with extend/overflow/decimal flags
`timescale 1ns/10ps
// How it works
// - binary additions are plain unsigned 16-bit sums kept modulo 2^16.
// - a carry out of bit 15 during a binary addition sets the extend flag.
// - a one's complement op replaces the accumulator with its inversion.
// - a two's complement op replaces the accumulator with inversion plus one.
// - overflow detection only watches the add and never alters the sum.
// - bit 15 is the sign, giving a signed range of -32768 to +32767.
// - a carry out of the top BCD digit sets the decimal carry flag.
// - overflow is set on the xor of the carries out of bits 14 and 15.
// - the accumulator adds never take the extend flag as carry in.
module bac_unit (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire bac_pkg::bac_op_t OP,
    input wire logic [15:0] OPERAND,
    output logic [15:0] ACC_A,
    output logic [15:0] ACC_B,
    output logic EXTEND,
    output logic OVERFLOW_FLAG,
    output logic DECIMAL_CARRY_FLAG,
    output logic NEGATIVE,
    output logic DONE
);

    bac_pkg::bac_state_t state_reg;
    bac_pkg::bac_state_t state_next;

    // 16-bit add with carries out of bit 14 and 15; carry in is always zero
    function automatic logic [17:0] add16(input logic [15:0] a,
                                          input logic [15:0] b);
        logic [15:0] low;
        logic [1:0] top;
        low = {1'b0, a[14:0]} + {1'b0, b[14:0]};
        top = {1'b0, a[15]} + {1'b0, b[15]} + {1'b0, low[15]};
        // {carry15, carry14, sum}
        add16 = {top[1], low[15], top[0], low[14:0]};
    endfunction : add16

    // digit-by-digit bcd add; returns {carry out of top digit, sum}
    function automatic logic [16:0] bcd_add(input logic [15:0] a,
                                            input logic [15:0] b);
        logic [4:0] dig;
        logic c;
        logic [15:0] s;
        c = 1'b0;
        s = 16'h0000;
        for (int i = 0; i < bac_pkg::DIGITS; i++) begin
            dig = {1'b0, a[i*4 +: 4]} + {1'b0, b[i*4 +: 4]} + {4'h0, c};
            c = (dig > 5'h09);
            if (c) begin
                dig = dig + 5'h06;
            end
            s[i*4 +: 4] = dig[3:0];
        end
        bcd_add = {c, s};
    endfunction : bcd_add

    logic [17:0] add_res;
    logic [16:0] bcd_res;
    logic [15:0] add_src;

    // next state from the issued op; flags are sticky until cleared
    always_comb begin
        state_next = state_reg;
        state_next.done = 1'b0;
        add_src = (OP == bac_pkg::BAC_ADD_TO_ACC_B) ? state_reg.acc_b
                                                    : state_reg.acc_a;
        add_res = add16(add_src, OPERAND);
        bcd_res = bcd_add(state_reg.acc_a, OPERAND);
        case (OP)
            bac_pkg::BAC_ADD_TO_ACC_A,
            bac_pkg::BAC_ADD_TO_ACC_B: begin
                // sum written untouched by overflow logic
                if (OP == bac_pkg::BAC_ADD_TO_ACC_A) begin
                    state_next.acc_a = add_res[15:0];
                end else begin
                    state_next.acc_b = add_res[15:0];
                end
                if (add_res[17]) begin
                    state_next.flags.extend = 1'b1;
                end
                if (add_res[17] ^ add_res[16]) begin
                    state_next.flags.overflow = 1'b1;
                end
                state_next.done = 1'b1;
            end
            bac_pkg::BAC_ONES_COMPLEMENT_ACC_A: begin
                state_next.acc_a = ~state_reg.acc_a;
                state_next.done = 1'b1;
            end
            bac_pkg::BAC_ONES_COMPLEMENT_ACC_B: begin
                state_next.acc_b = ~state_reg.acc_b;
                state_next.done = 1'b1;
            end
            bac_pkg::BAC_TWOS_COMPLEMENT_ACC_A: begin
                state_next.acc_a = ~state_reg.acc_a + 16'h0001;
                state_next.done = 1'b1;
            end
            bac_pkg::BAC_TWOS_COMPLEMENT_ACC_B: begin
                state_next.acc_b = ~state_reg.acc_b + 16'h0001;
                state_next.done = 1'b1;
            end
            bac_pkg::BAC_BCD_ADD_ACC_A: begin
                state_next.acc_a = bcd_res[15:0];
                if (bcd_res[16]) begin
                    state_next.flags.decimal_carry = 1'b1;
                end
                state_next.done = 1'b1;
            end
            bac_pkg::BAC_CLEAR_EXTEND: begin
                state_next.flags.extend = 1'b0;
                state_next.done = 1'b1;
            end
            bac_pkg::BAC_CLEAR_OVERFLOW: begin
                state_next.flags.overflow = 1'b0;
                state_next.done = 1'b1;
            end
            bac_pkg::BAC_CLEAR_DECIMAL_CARRY: begin
                state_next.flags.decimal_carry = 1'b0;
                state_next.done = 1'b1;
            end
            default: begin
                state_next.done = 1'b0;
            end
        endcase
    end

    // one register for all state; reset clears accumulators and flags
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_reg <= '{acc_a: bac_pkg::ACC_RESET,
                           acc_b: bac_pkg::ACC_RESET,
                           flags: '0, done: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flip-flops; negative is the stored sign of acc a
    assign ACC_A = state_reg.acc_a;
    assign ACC_B = state_reg.acc_b;
    assign EXTEND = state_reg.flags.extend;
    assign OVERFLOW_FLAG = state_reg.flags.overflow;
    assign DECIMAL_CARRY_FLAG = state_reg.flags.decimal_carry;
    assign NEGATIVE = state_reg.acc_a[bac_pkg::SIGN_BIT];
    assign DONE = state_reg.done;

    // assertions share the one clock and sleep while reset is high
    default clocking cb_unit @(posedge CLOCK);
    endclocking
    default disable iff (SYS_RST);

    // plain modulo sum into accumulator a
    a_add_modulo_a: assert property (
        OP == bac_pkg::BAC_ADD_TO_ACC_A |=>
        ACC_A == 16'($past(ACC_A) + $past(OPERAND)))
        else $error("add to acc a sum wrong");

    // carry out of bit 15 must raise extend
    a_extend_set: assert property (
        OP == bac_pkg::BAC_ADD_TO_ACC_B &&
        ({1'b0, ACC_B} + {1'b0, OPERAND} > 17'h0FFFF) |=> EXTEND)
        else $error("extend not set on carry out");

    // one's complement as all ones minus the value
    a_ones_comp: assert property (
        OP == bac_pkg::BAC_ONES_COMPLEMENT_ACC_B |=>
        ACC_B == 16'hFFFF - $past(ACC_B))
        else $error("one's complement wrong");

    // negation sums to zero and leaves acc b alone
    a_twos_comp: assert property (
        OP == bac_pkg::BAC_TWOS_COMPLEMENT_ACC_A |=>
        16'(ACC_A + $past(ACC_A)) == 16'h0000 && ACC_B == $past(ACC_B))
        else $error("two's complement wrong");

    // an overflowing add still writes the plain sum
    a_ovf_sum_kept: assert property (
        OP == bac_pkg::BAC_ADD_TO_ACC_A && ACC_A[15] == OPERAND[15] &&
        ACC_A[15] != 1'(16'(ACC_A + OPERAND) >> 15) |=>
        OVERFLOW_FLAG && ACC_A == 16'($past(ACC_A) + $past(OPERAND)))
        else $error("sum altered by overflow");

    // negating a value other than zero or the most negative flips the sign
    a_sign_track: assert property (
        OP == bac_pkg::BAC_TWOS_COMPLEMENT_ACC_A && ACC_A != 16'h0000 &&
        ACC_A != bac_pkg::SIGNED_MIN |=> NEGATIVE != $past(NEGATIVE))
        else $error("sign did not flip on negation");

    // carry out of the top digit of a bcd add
    a_dec_carry_set: assert property (
        OP == bac_pkg::BAC_BCD_ADD_ACC_A && ACC_A == 16'h9999 &&
        OPERAND == 16'h0001 |=> DECIMAL_CARRY_FLAG && ACC_A == 16'h0000)
        else $error("decimal carry not set");

    // opposite signs give both carries or neither, so never overflow
    a_ovf_xor: assert property (
        OP == bac_pkg::BAC_ADD_TO_ACC_B && !OVERFLOW_FLAG &&
        ACC_B[15] != OPERAND[15] |=> !OVERFLOW_FLAG)
        else $error("overflow set with both or neither carry");

    // a set extend flag never sneaks into the sum
    a_no_carry_in: assert property (
        EXTEND && OP == bac_pkg::BAC_ADD_TO_ACC_A |=>
        ACC_A == 16'($past(ACC_A) + $past(OPERAND)))
        else $error("extend used as carry in");

    // complement lands in one step in its own accumulator
    a_comp_onestep: assert property (
        OP == bac_pkg::BAC_ONES_COMPLEMENT_ACC_A |=>
        DONE && ACC_A == ~$past(ACC_A) && ACC_B == $past(ACC_B))
        else $error("complement not in one step");

    // main scenarios the bench walks through
    c_add_ovf: cover property (
        OP == bac_pkg::BAC_ADD_TO_ACC_A ##1 OVERFLOW_FLAG);
    c_add_ext: cover property (
        OP == bac_pkg::BAC_ADD_TO_ACC_B ##1 EXTEND);
    c_twos: cover property (
        OP == bac_pkg::BAC_TWOS_COMPLEMENT_ACC_B ##1 DONE);
    c_dec_carry: cover property (
        OP == bac_pkg::BAC_BCD_ADD_ACC_A ##1 DECIMAL_CARRY_FLAG);

endmodule : bac_unit

// >>> tb/bac_issuer.sv
// partner model: decoder side that issues one operation per call
`timescale 1ns/10ps
module bac_issuer (
    input wire logic CLOCK,
    output bac_pkg::bac_op_t OP,
    output logic [15:0] OPERAND
);
    // idle at time zero so the unit sees no stray op
    initial begin
        OP = bac_pkg::BAC_NOP;
        OPERAND = 16'h0000;
    end

    // change on the falling edge; idle operand flips so no stale addend
    task automatic issue(input bac_pkg::bac_op_t op, input logic [15:0] v);
        @(negedge CLOCK);
        OP = op;
        OPERAND = (op == bac_pkg::BAC_NOP) ? ~OPERAND : v;
    endtask : issue
endmodule : bac_issuer

// >>> tb/bac_unit_tb.sv
// self-checking bench for the binary add and complement unit
`timescale 1ns/10ps
module bac_unit_tb;
    // op code, addend, expected acc a, acc b, {extend, overflow, dec carry}
    typedef struct packed {
        logic [3:0] op;
        logic [15:0] val;
        logic [15:0] a;
        logic [15:0] b;
        logic [2:0] f;
    } bac_row_t;
    logic CLOCK;
    logic SYS_RST;
    bac_pkg::bac_op_t OP;
    logic [15:0] OPERAND, ACC_A, ACC_B;
    logic EXTEND, OVERFLOW_FLAG, DECIMAL_CARRY_FLAG, NEGATIVE, DONE;
    wire [4:0] flags_out = {EXTEND, OVERFLOW_FLAG, DECIMAL_CARRY_FLAG,
                            NEGATIVE, DONE};
    int n_tests = 0;
    int fail_count = 0;
    logic [4:0] exp_flags;
    // codes follow the package enum order; flags are sticky between rows
    bac_row_t rows [20] = '{
        '{4'h1, 16'h7FFF, 16'h7FFF, 16'h0000, 3'h0}, // add a
        '{4'h1, 16'h0001, 16'h8000, 16'h0000, 3'h2}, // carry 14 only
        '{4'h9, 16'h0000, 16'h8000, 16'h0000, 3'h0}, // clear overflow
        '{4'h1, 16'h8000, 16'h0000, 16'h0000, 3'h6}, // carry 15 only
        '{4'h1, 16'h0001, 16'h0001, 16'h0000, 3'h6}, // extend not added
        '{4'h8, 16'h0000, 16'h0001, 16'h0000, 3'h2}, // clear extend
        '{4'h9, 16'h0000, 16'h0001, 16'h0000, 3'h0},
        '{4'h3, 16'h1234, 16'hFFFE, 16'h0000, 3'h0}, // ones a
        '{4'h5, 16'h1234, 16'h0002, 16'h0000, 3'h0}, // twos a
        '{4'h2, 16'h0005, 16'h0002, 16'h0005, 3'h0}, // add b
        '{4'h6, 16'h0000, 16'h0002, 16'hFFFB, 3'h0}, // twos b
        '{4'h4, 16'h0000, 16'h0002, 16'h0004, 3'h0}, // ones b
        '{4'h2, 16'hFFFC, 16'h0002, 16'h0000, 3'h4}, // both carries
        '{4'h5, 16'h0000, 16'hFFFE, 16'h0000, 3'h4},
        '{4'h1, 16'h0002, 16'h0000, 16'h0000, 3'h4},
        '{4'h5, 16'h0000, 16'h0000, 16'h0000, 3'h4}, // twos of zero
        '{4'h8, 16'h0000, 16'h0000, 16'h0000, 3'h0},
        '{4'h7, 16'h9999, 16'h9999, 16'h0000, 3'h0}, // bcd top value
        '{4'h7, 16'h0001, 16'h0000, 16'h0000, 3'h1}, // top digit carry
        '{4'hA, 16'h0000, 16'h0000, 16'h0000, 3'h0}  // clear dec carry
    };

    bac_issuer i_dec (.CLOCK(CLOCK), .OP(OP), .OPERAND(OPERAND));

    bac_unit i_dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .OP(OP),
        .OPERAND(OPERAND), .ACC_A(ACC_A), .ACC_B(ACC_B), .EXTEND(EXTEND),
        .OVERFLOW_FLAG(OVERFLOW_FLAG),
        .DECIMAL_CARRY_FLAG(DECIMAL_CARRY_FLAG), .NEGATIVE(NEGATIVE),
        .DONE(DONE));

    // free-running 10 MHz clock
    initial begin
        CLOCK = 1'b0;
        forever #50 CLOCK = ~CLOCK;
    end

    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
            fail_count++;
        if (got !== exp)
            $display("unexpected at %0t: word %h want %h", $time, got, exp);
    endtask : check16

    task automatic check_flags(input logic [4:0] got, input logic [4:0] exp);
        n_tests++;
        if (got !== exp)
            fail_count++;
        if (got !== exp)
            $display("unexpected at %0t: flags %b want %b", $time, got, exp);
    endtask : check_flags

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    // guard against a hang; the whole run needs well under this
    initial begin
        #100000;
        fail_count++;
        $display("unexpected at %0t: run did not finish", $time);
        finish_test();
    end

    // main sequence: reset, table rows, then awkward cases
    initial begin
        SYS_RST = 1'b1;
        repeat (12) @(posedge CLOCK);
        @(negedge CLOCK);
        SYS_RST = 1'b0;
        foreach (rows[i]) begin
            i_dec.issue(bac_pkg::bac_op_t'(rows[i].op), rows[i].val);
            i_dec.issue(bac_pkg::BAC_NOP, 16'h0000);
            check16(ACC_A, rows[i].a);
            check16(ACC_B, rows[i].b);
            exp_flags = {rows[i].f, rows[i].a[15], 1'b1};
            check_flags(flags_out, exp_flags);
        end
        $display("table rows done");
        // back-to-back adds, one per cycle, none lost
        repeat (3) i_dec.issue(bac_pkg::BAC_ADD_TO_ACC_A, 16'h0001);
        check_flags(flags_out, 5'b00001);
        i_dec.issue(bac_pkg::BAC_NOP, 16'h0000);
        check16(ACC_A, 16'h0003);
        $display("back to back done");
        // undefined code must leave everything alone
        i_dec.issue(bac_pkg::bac_op_t'(4'hF), 16'h1111);
        i_dec.issue(bac_pkg::BAC_NOP, 16'h0000);
        check16(ACC_A, 16'h0003);
        check_flags(flags_out, 5'b00000);
        $display("unknown code done");
        // second reset mid-run with both flags and acc b loaded first
        i_dec.issue(bac_pkg::BAC_ADD_TO_ACC_B, 16'h8000);
        i_dec.issue(bac_pkg::BAC_ADD_TO_ACC_B, 16'h8001);
        i_dec.issue(bac_pkg::BAC_NOP, 16'h0000);
        check16(ACC_B, 16'h0001);
        check_flags(flags_out, 5'b11001);
        SYS_RST = 1'b1;
        @(negedge CLOCK);
        check16(ACC_A | ACC_B, 16'h0000);
        check_flags(flags_out, 5'b00000);
        SYS_RST = 1'b0;
        i_dec.issue(bac_pkg::BAC_ADD_TO_ACC_B, 16'h8000);
        i_dec.issue(bac_pkg::BAC_NOP, 16'h0000);
        check16(ACC_B, 16'h8000);
        check_flags(flags_out, 5'b00001);
        $display("mid-run reset done");
        finish_test();
    end
endmodule : bac_unit_tb
